// >>> hdl/hxmii_map.svh
`ifndef HXMII_MAP_SVH
`define HXMII_MAP_SVH

`define HXM_N_PORTS     6
`define HXM_NIB_W       4
`define HXM_SYM_W       5
`define HXM_CNT_W       8
`define HXM_CLK_HZ      200000000
`define HXM_RATE100_HZ  25000000
`define HXM_RATE10_HZ   2500000
`define HXM_DIV100      (`HXM_CLK_HZ / `HXM_RATE100_HZ)
`define HXM_DIV10       (`HXM_CLK_HZ / `HXM_RATE10_HZ)
`define HXM_SFD_FIRST   4'h5
`define HXM_SFD_SECOND  4'hd
`define HXM_BAD_FIRST   4'ha
`define HXM_BAD_SECOND  4'h2

`endif

// >>> hdl/hxmii_pkg.sv
`include "hxmii_map.svh"

package hxmii_pkg;

    typedef logic [`HXM_NIB_W-1:0] hxm_nib_type;
    typedef logic [`HXM_SYM_W-1:0] hxm_sym_type;
    typedef logic [`HXM_CNT_W-1:0] hxm_cnt_type;

    typedef enum logic [1:0] {
        HXM_RX_IDLE,
        HXM_RX_HUNT,
        HXM_RX_FRAME
    } hxm_rx_state_type;

    // Divider ratio of the link clock for the selected speed
    function automatic hxm_cnt_type hxm_div(input logic speed100);
        hxm_div = speed100 ? hxm_cnt_type'(`HXM_DIV100)
                           : hxm_cnt_type'(`HXM_DIV10);
    endfunction

endpackage

// >>> hdl/hxmii_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "hxmii_map.svh"

interface hxmii_if #(parameter int N = `HXM_N_PORTS);
    logic [N-1:0]                 tx_clk;
    logic [N-1:0]                 tx_en;
    logic [N-1:0]                 tx_er;
    logic [N-1:0][`HXM_NIB_W-1:0] txd;
    logic [N-1:0]                 rx_clk;
    logic [N-1:0]                 rx_dv;
    logic [N-1:0]                 rx_er;
    logic [N-1:0][`HXM_NIB_W-1:0] rxd;
    logic [N-1:0]                 crs;
    logic [N-1:0]                 col;

    modport phy (
        output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col,
        input  txd, tx_en, tx_er
    );

    modport mac (
        input  tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col,
        output txd, tx_en, tx_er
    );
endinterface

`default_nettype wire

// >>> hdl/hxmii_phy.sv
// What this block does
// - Six independent MII ports, numbered zero to five
// - Four-bit transmit nibbles clocked in on TX_CLK
// - Symbol mode: TX_ER is transmit bit four
// - Transmitter enabled only while TX_EN is high
// - TX_ER at 100 Mbps sends Halt code
// - TX_CLK is 25 or 2.5 MHz
// - Transmit signals sampled on TX_CLK rising edge
// - Receive nibbles driven synchronous to RX_CLK
// - Symbol mode: RX_ER is receive bit four
// - CRS asserts at once on carrier
// - CRS negates synchronous to RX_CLK
// - COL high on simultaneous receive and transmit
// - COL held low in full duplex
// - RX_DV high while receiving valid data
// - 10 Mbps: RX_DV starts with SFD nibble
// - RX_ER on bad code at 100 Mbps or unlocked PLL
// - 10 Mbps: RX_ER when SFD reads A2
// - Continuous RX_CLK at 25 or 2.5 MHz
`timescale 1ns/1ps
`default_nettype none
`include "hxmii_map.svh"

module hxmii_phy
    import hxmii_pkg::*;
#(
    parameter int N_PORTS = `HXM_N_PORTS
) (
    // System
    input  wire logic                    CLK_I,
    input  wire logic                    RST_B_I,
    // Per-port mode
    input  wire logic [N_PORTS-1:0]      SPEED100_I,
    input  wire logic [N_PORTS-1:0]      FULL_DUPLEX_I,
    input  wire logic [N_PORTS-1:0]      SYMBOL_MODE_I,
    // Line side, transmit
    output logic [N_PORTS-1:0]           LINE_TX_STB_O,
    output logic [N_PORTS-1:0]           LINE_TX_EN_O,
    output logic [N_PORTS-1:0]           LINE_TX_HALT_O,
    output hxm_sym_type [N_PORTS-1:0]    LINE_TX_CODE_O,
    // Line side, receive
    input  wire logic [N_PORTS-1:0]      LINE_RX_ACT_I,
    input  wire logic [N_PORTS-1:0]      LINE_RX_BAD_I,
    input  wire logic [N_PORTS-1:0]      LINE_RX_LOCK_I,
    input  wire hxm_sym_type [N_PORTS-1:0] LINE_RX_CODE_I,
    output logic [N_PORTS-1:0]           LINE_RX_STB_O,
    // MII towards the MAC
    hxmii_if.phy                         mii
);

    genvar p;
    generate
        for (p = 0; p < N_PORTS; p++) begin : g_port
            hxm_cnt_type      cnt_r;
            hxm_cnt_type      cnt_nxt;
            hxm_cnt_type      div;
            hxm_cnt_type      half;
            logic             clk_r;
            logic             rise;
            logic             fall;
            logic [5:0]       tx_s1_r;
            logic [5:0]       tx_s2_r;
            logic             tx_en_s;
            logic             tx_er_s;
            hxm_nib_type      txd_s;
            logic             tx_act_r;
            logic             tx_stb_r;
            logic             tx_en_r;
            logic             tx_halt_r;
            hxm_sym_type      tx_code_r;
            hxm_sym_type      tx_code_nxt;
            logic             sym;
            logic             fast;
            logic             fdx;
            hxm_sym_type      d1_r;
            logic             act_d1_r;
            logic             bad_d1_r;
            logic             lock_d1_r;
            hxm_nib_type      cur_nib;
            logic             sfd_hit;
            logic             a2_hit;
            hxm_rx_state_type st_r;
            hxm_rx_state_type st_nxt;
            logic             frm_bad_r;
            logic             frm_bad_nxt;
            logic             dv10_nxt;
            logic             dv_nxt;
            logic             er_nxt;
            hxm_nib_type      rxd_nxt;
            logic             dv_r;
            logic             er_r;
            hxm_nib_type      rxd_r;
            logic             rx_stb_r;
            logic             carrier;
            logic             crs_r;
            logic             crs_nxt;
            logic             col_r;
            logic             col_nxt;

            assign sym  = SYMBOL_MODE_I[p];
            assign fast = SPEED100_I[p];
            assign fdx  = FULL_DUPLEX_I[p];

            // One divider feeds both link clocks; a speed change can
            // leave the count above the new ratio, so wrap on >=.
            assign div     = hxm_div(fast);
            assign half    = div >> 1;
            assign rise    = (cnt_r >= div - hxm_cnt_type'(1));
            assign fall    = (cnt_r == half - hxm_cnt_type'(1));
            assign cnt_nxt = rise ? '0 : cnt_r + hxm_cnt_type'(1);

            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    // Start at the wrap so the first period is full length
                    cnt_r <= '1;
                    clk_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_nxt;
                    clk_r <= (cnt_nxt < half);
                end
            end

            // Transmit pins come from the MAC's clock tree
            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    tx_s1_r <= '0;
                    tx_s2_r <= '0;
                end else begin
                    tx_s1_r <= {mii.tx_er[p], mii.tx_en[p], mii.txd[p]};
                    tx_s2_r <= tx_s1_r;
                end
            end

            assign txd_s   = tx_s2_r[3:0];
            assign tx_en_s = tx_s2_r[4];
            assign tx_er_s = tx_s2_r[5];
            assign tx_code_nxt = sym ? {tx_er_s, txd_s}
                                     : {1'b0, txd_s};

            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    tx_stb_r  <= 1'b0;
                    tx_en_r   <= 1'b0;
                    tx_halt_r <= 1'b0;
                    tx_code_r <= '0;
                    tx_act_r  <= 1'b0;
                end else begin
                    tx_stb_r <= rise;
                    if (rise) begin
                        tx_en_r   <= tx_en_s;
                        tx_act_r  <= tx_en_s;
                        tx_code_r <= tx_code_nxt;
                        // Error line only sends Halt at 100 Mbps outside symbol mode
                        tx_halt_r <= fast & ~sym
                                   & tx_en_s & tx_er_s;
                    end
                end
            end

            // Receive path runs one nibble behind the line so that the
            // first SFD nibble can be qualified by the second.
            assign cur_nib = LINE_RX_CODE_I[p][3:0];
            assign sfd_hit = (d1_r[3:0] == `HXM_SFD_FIRST)
                           & (cur_nib == `HXM_SFD_SECOND)
                           & LINE_RX_ACT_I[p];
            assign a2_hit  = (d1_r[3:0] == `HXM_BAD_FIRST)
                           & (cur_nib == `HXM_BAD_SECOND)
                           & LINE_RX_ACT_I[p];

            always_comb begin
                st_nxt      = st_r;
                frm_bad_nxt = frm_bad_r;
                dv10_nxt    = 1'b0;
                case (st_r)
                    HXM_RX_IDLE: begin
                        frm_bad_nxt = 1'b0;
                        if (act_d1_r) begin
                            st_nxt = HXM_RX_HUNT;
                        end
                    end
                    HXM_RX_HUNT: begin
                        if (!act_d1_r) begin
                            st_nxt = HXM_RX_IDLE;
                        end else if (sfd_hit || a2_hit) begin
                            st_nxt      = HXM_RX_FRAME;
                            frm_bad_nxt = a2_hit;
                            dv10_nxt    = 1'b1;
                        end
                    end
                    HXM_RX_FRAME: begin
                        dv10_nxt = act_d1_r;
                        if (!act_d1_r) begin
                            st_nxt = HXM_RX_IDLE;
                        end
                    end
                    default: begin
                        st_nxt = HXM_RX_IDLE;
                    end
                endcase
            end

            assign dv_nxt  = (fast | sym) ? act_d1_r : dv10_nxt;
            assign rxd_nxt = d1_r[3:0];
            assign er_nxt  = sym ? d1_r[4]
                           : (~lock_d1_r
                             | (fast & act_d1_r & bad_d1_r)
                             | (~fast & dv10_nxt & frm_bad_nxt));

            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    d1_r      <= '0;
                    act_d1_r  <= 1'b0;
                    bad_d1_r  <= 1'b0;
                    lock_d1_r <= 1'b0;
                    st_r      <= HXM_RX_IDLE;
                    frm_bad_r <= 1'b0;
                    rxd_r     <= '0;
                    dv_r      <= 1'b0;
                    er_r      <= 1'b0;
                    rx_stb_r  <= 1'b0;
                end else begin
                    rx_stb_r <= fall;
                    // Outputs move on the falling edge, mid-bit for MAC
                    if (fall) begin
                        d1_r      <= LINE_RX_CODE_I[p];
                        act_d1_r  <= LINE_RX_ACT_I[p];
                        bad_d1_r  <= LINE_RX_BAD_I[p];
                        lock_d1_r <= LINE_RX_LOCK_I[p];
                        st_r      <= st_nxt;
                        frm_bad_r <= frm_bad_nxt;
                        rxd_r     <= rxd_nxt;
                        dv_r      <= dv_nxt;
                        er_r      <= er_nxt;
                    end
                end
            end

            assign carrier = LINE_RX_ACT_I[p] | (~fdx & tx_act_r);
            assign crs_nxt = carrier | (crs_r & ~fall);
            assign col_nxt = ~fdx & LINE_RX_ACT_I[p] & tx_act_r;

            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    crs_r <= 1'b0;
                    col_r <= 1'b0;
                end else begin
                    crs_r <= crs_nxt;
                    col_r <= col_nxt;
                end
            end

            assign mii.tx_clk[p]     = clk_r;
            assign mii.rx_clk[p]     = clk_r;
            assign mii.rxd[p]        = rxd_r;
            assign mii.rx_dv[p]      = dv_r;
            assign mii.rx_er[p]      = er_r;
            assign mii.crs[p]        = crs_r;
            assign mii.col[p]        = col_r;
            assign LINE_TX_STB_O[p]  = tx_stb_r;
            assign LINE_TX_EN_O[p]   = tx_en_r;
            assign LINE_TX_HALT_O[p] = tx_halt_r;
            assign LINE_TX_CODE_O[p] = tx_code_r;
            assign LINE_RX_STB_O[p]  = rx_stb_r;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> hdl/hxmii_mac.sv
`timescale 1ns/1ps
`default_nettype none
`include "hxmii_map.svh"

module hxmii_mac
    import hxmii_pkg::*;
#(
    parameter int N_PORTS = `HXM_N_PORTS
) (
    // System
    input  wire logic                      CLK_I,
    input  wire logic                      RST_B_I,
    // Per-port mode
    input  wire logic [N_PORTS-1:0]        SYMBOL_MODE_I,
    // Transmit user side, synchronous to mii.tx_clk
    input  wire logic [N_PORTS-1:0]        TX_VALID_I,
    input  wire hxm_nib_type [N_PORTS-1:0] TX_DATA_I,
    input  wire logic [N_PORTS-1:0]        TX_ERR_I,
    input  wire logic [N_PORTS-1:0]        TX_SYMBOL_BIT_FOUR_I,
    // Receive user side, synchronous to mii.rx_clk
    output logic [N_PORTS-1:0]             RX_VALID_O,
    output logic [N_PORTS-1:0]             RX_ERR_O,
    output hxm_sym_type [N_PORTS-1:0]      RX_DATA_O,
    // Status, synchronous to CLK_I
    output logic [N_PORTS-1:0]             CARRIER_O,
    output logic [N_PORTS-1:0]             COLLISION_O,
    output logic [N_PORTS-1:0]             FRAME_DONE_O,
    output logic [N_PORTS-1:0]             FRAME_BAD_O,
    // MII towards the PHY
    hxmii_if.mac                           mii
);

    genvar p;
    generate
        for (p = 0; p < N_PORTS; p++) begin : g_port
            logic        tsym_s1_r;
            logic        tsym_s2_r;
            hxm_nib_type txd_r;
            logic        txen_r;
            logic        txer_r;
            logic        rsym_s1_r;
            logic        rsym_s2_r;
            logic        rdv_r;
            logic        rbad_r;
            logic        bad_hold_r;
            logic        done_tgl_r;
            logic        rxv_r;
            logic        rxe_r;
            hxm_sym_type rxd_r;
            logic [1:0]  crs_s_r;
            logic [1:0]  col_s_r;
            logic [2:0]  done_s_r;
            logic        done_r;
            logic        bad_r;
            logic        frame_end;

            // Launched on the rising edge, the PHY takes it next rise
            always_ff @(posedge mii.tx_clk[p] or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    tsym_s1_r <= 1'b0;
                    tsym_s2_r <= 1'b0;
                    txd_r     <= '0;
                    txen_r    <= 1'b0;
                    txer_r    <= 1'b0;
                end else begin
                    tsym_s1_r <= SYMBOL_MODE_I[p];
                    tsym_s2_r <= tsym_s1_r;
                    txd_r     <= TX_DATA_I[p];
                    txen_r    <= TX_VALID_I[p];
                    txer_r    <= tsym_s2_r ? TX_SYMBOL_BIT_FOUR_I[p]
                                           : TX_ERR_I[p];
                end
            end

            assign frame_end = rdv_r & ~mii.rx_dv[p];

            // RX_CLK runs continuously, so frame end needs no other clock
            always_ff @(posedge mii.rx_clk[p] or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    rsym_s1_r  <= 1'b0;
                    rsym_s2_r  <= 1'b0;
                    rdv_r      <= 1'b0;
                    rbad_r     <= 1'b0;
                    bad_hold_r <= 1'b0;
                    done_tgl_r <= 1'b0;
                    rxv_r      <= 1'b0;
                    rxe_r      <= 1'b0;
                    rxd_r      <= '0;
                end else begin
                    rsym_s1_r <= SYMBOL_MODE_I[p];
                    rsym_s2_r <= rsym_s1_r;
                    rdv_r     <= mii.rx_dv[p];
                    rxv_r     <= mii.rx_dv[p];
                    rxe_r     <= ~rsym_s2_r & mii.rx_er[p];
                    rxd_r     <= rsym_s2_r ? {mii.rx_er[p], mii.rxd[p]}
                                           : {1'b0, mii.rxd[p]};
                    if (frame_end) begin
                        bad_hold_r <= rbad_r;
                        done_tgl_r <= ~done_tgl_r;
                        rbad_r     <= 1'b0;
                    end else if (mii.rx_dv[p] && mii.rx_er[p]) begin
                        rbad_r <= 1'b1;
                    end
                end
            end

            // bad_hold_r is stable for a whole frame after the toggle
            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    crs_s_r  <= '0;
                    col_s_r  <= '0;
                    done_s_r <= '0;
                    done_r   <= 1'b0;
                    bad_r    <= 1'b0;
                end else begin
                    crs_s_r  <= {crs_s_r[0], mii.crs[p]};
                    col_s_r  <= {col_s_r[0], mii.col[p]};
                    done_s_r <= {done_s_r[1:0], done_tgl_r};
                    done_r   <= done_s_r[2] ^ done_s_r[1];
                    if (done_s_r[2] ^ done_s_r[1]) begin
                        bad_r <= bad_hold_r;
                    end
                end
            end

            assign mii.txd[p]      = txd_r;
            assign mii.tx_en[p]    = txen_r;
            assign mii.tx_er[p]    = txer_r;
            assign RX_VALID_O[p]   = rxv_r;
            assign RX_ERR_O[p]     = rxe_r;
            assign RX_DATA_O[p]    = rxd_r;
            assign CARRIER_O[p]    = crs_s_r[1];
            assign COLLISION_O[p]  = col_s_r[1];
            assign FRAME_DONE_O[p] = done_r;
            assign FRAME_BAD_O[p]  = bad_r;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> sim/hxmii_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "hxmii_map.svh"

module hxm_asserts #(
    parameter int N = `HXM_N_PORTS
) (
    // System and modes
    input wire logic                         CLK_I,
    input wire logic                         RST_B_I,
    input wire logic [N-1:0]                 SPEED100_I,
    input wire logic [N-1:0]                 FULL_DUPLEX_I,
    // Link signals
    input wire logic [N-1:0]                 tx_clk,
    input wire logic [N-1:0]                 rx_clk,
    input wire logic [N-1:0]                 tx_en,
    input wire logic [N-1:0]                 tx_er,
    input wire logic [N-1:0][`HXM_NIB_W-1:0] txd,
    input wire logic [N-1:0][`HXM_NIB_W-1:0] rxd,
    input wire logic [N-1:0]                 rx_dv,
    input wire logic [N-1:0]                 rx_er,
    input wire logic [N-1:0]                 crs,
    input wire logic [N-1:0]                 col
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    for (genvar p = 0; p < N; p++) begin : g_port
        logic [7:0] hi_cnt_r;
        // Speed only changes under reset, so one count serves both rates
        always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
                hi_cnt_r <= 8'h00;
            end else begin
                hi_cnt_r <= tx_clk[p] ? hi_cnt_r + 8'h01 : 8'h00;
            end
        end
        sequence s_fast_period;
            tx_clk[p] [*4] ##1 !tx_clk[p] [*4] ##1 tx_clk[p];
        endsequence
        a_clk_fast_period: assert property (
            $rose(tx_clk[p]) && SPEED100_I[p] |-> s_fast_period)
            else $error("fast link clock period wrong");
        a_clk_high_time: assert property (
            $fell(tx_clk[p]) |-> hi_cnt_r == (SPEED100_I[p] ? 8'h04 : 8'h28))
            else $error("link clock high time wrong");
        a_rx_clk_runs: assert property (
            $changed(rx_clk[p]) |-> ##[4:40] $changed(rx_clk[p]))
            else $error("receive clock stopped or out of rate");
        a_rx_out_sync: assert property (
            !$fell(rx_clk[p]) |-> $stable({rxd[p], rx_dv[p], rx_er[p]}))
            else $error("receive outputs moved off the clock edge");
        a_crs_fall_sync: assert property (
            $fell(crs[p]) |-> $fell(rx_clk[p]))
            else $error("carrier dropped off the receive clock edge");
        a_tx_mac_sync: assert property (
            !$rose(tx_clk[p]) |-> $stable({txd[p], tx_en[p], tx_er[p]}))
            else $error("transmit inputs moved off the clock edge");
        a_col_full_dup: assert property (
            FULL_DUPLEX_I[p] && $past(FULL_DUPLEX_I[p]) |-> !col[p])
            else $error("collision raised in full duplex");
        a_col_with_crs: assert property (
            col[p] |-> crs[p])
            else $error("collision without carrier");
    end
endmodule

`default_nettype wire

// >>> sim/tb_hex_phy_mii_data_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "hxmii_map.svh"

`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end

module tb_hex_phy_mii_data_port
    import hxmii_pkg::*;
;
    localparam int N = `HXM_N_PORTS;
    logic                   CLK_I = 1'b0;
    logic                   RST_B_I = 1'b0;
    logic [N-1:0]           spd = '1, fdx = '0, sym = '0, act = '0;
    logic [N-1:0]           bad = '0, lock = '1, tvld = '0, terr = '0;
    logic [N-1:0]           tb4 = '0;
    logic [N-1:0]           rstb;
    hxm_nib_type [N-1:0]    tdat = '0;
    hxm_sym_type [N-1:0]    rcode = '0;
    logic [N-1:0]           stb, ten, halt, rvld, rerr, car, coll, fdone, fbad;
    hxm_sym_type [N-1:0]    tcode, rdat;
    int                     failures = 0;
    int                     compares = 0;

    always #2.5 CLK_I = ~CLK_I;

    hxmii_if #(.N(N)) mii_bus ();
    hxmii_phy #(.N_PORTS(N)) hxmii_phy_inst (.CLK_I(CLK_I),
        .RST_B_I(RST_B_I), .SPEED100_I(spd), .FULL_DUPLEX_I(fdx),
        .SYMBOL_MODE_I(sym), .LINE_TX_STB_O(stb), .LINE_TX_EN_O(ten),
        .LINE_TX_HALT_O(halt), .LINE_TX_CODE_O(tcode), .LINE_RX_ACT_I(act),
        .LINE_RX_BAD_I(bad), .LINE_RX_LOCK_I(lock), .LINE_RX_CODE_I(rcode),
        .LINE_RX_STB_O(rstb), .mii(mii_bus));
    hxmii_mac #(.N_PORTS(N)) hxmii_mac_inst (.CLK_I(CLK_I),
        .RST_B_I(RST_B_I), .SYMBOL_MODE_I(sym), .TX_VALID_I(tvld),
        .TX_DATA_I(tdat), .TX_ERR_I(terr), .TX_SYMBOL_BIT_FOUR_I(tb4),
        .RX_VALID_O(rvld), .RX_ERR_O(rerr), .RX_DATA_O(rdat),
        .CARRIER_O(car), .COLLISION_O(coll), .FRAME_DONE_O(fdone),
        .FRAME_BAD_O(fbad), .mii(mii_bus));
    hxm_asserts #(.N(N)) hxm_asserts_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
        .SPEED100_I(spd), .FULL_DUPLEX_I(fdx), .tx_clk(mii_bus.tx_clk),
        .rx_clk(mii_bus.rx_clk), .tx_en(mii_bus.tx_en), .tx_er(mii_bus.tx_er),
        .txd(mii_bus.txd), .rxd(mii_bus.rxd), .rx_dv(mii_bus.rx_dv),
        .rx_er(mii_bus.rx_er), .crs(mii_bus.crs), .col(mii_bus.col));

    // Speed and symbol mode change only here so that every link clock starts clean
    task automatic do_reset(input logic s100, input logic sm);
        @(negedge CLK_I);
        RST_B_I = 1'b0;
        spd = {N{s100}};
        sym = {N{sm}};
        {fdx, act, bad, tvld, terr, tb4} = '0;
        lock = '1;
        repeat (5) @(negedge CLK_I);
        RST_B_I = 1'b1;
        repeat (4) @(negedge CLK_I);
    endtask

    task automatic tx_chk(input int p, input logic v, input hxm_nib_type d,
                          input logic e, input logic f, input logic h);
        @(negedge CLK_I);
        tvld[p] = v;
        tdat[p] = d;
        terr[p] = e;
        tb4[p] = f;
        repeat (3) @(posedge stb[p]);
        @(negedge CLK_I);
        `CHK("tx strobe", 1'b1, stb[p])
        `CHK("tx enable", v, ten[p])
        `CHK("tx halt", h, halt[p])
        if (v) `CHK("tx nibble", d, tcode[p][3:0])
    endtask

    // Each of the n passes spans one link period; rxd lags the line by two passes
    task automatic feed(input int p, input logic a, input logic b,
                        input logic l, input hxm_sym_type c, input int n);
        repeat (n) begin
            @(posedge mii_bus.rx_clk[p]);
            @(negedge CLK_I);
            act[p] = a;
            bad[p] = b;
            lock[p] = l;
            rcode[p] = c;
        end
    endtask

    task automatic t_tx();
        do_reset(1'b1, 1'b0);
        for (int p = 0; p < N; p++) begin
            tx_chk(p, 1, 4'(p + 3), 0, 0, 0);
        end
        tx_chk(0, 1, 4'h7, 1, 0, 1);
        tx_chk(1, 0, 4'h7, 1, 0, 0);
        do_reset(1'b0, 1'b0);
        tx_chk(2, 1, 4'hc, 1, 0, 0);
        do_reset(1'b0, 1'b1);
        tx_chk(3, 1, 4'h5, 0, 1, 0);
        `CHK("tx bit four", 1'b1, tcode[3][4])
        do_reset(1'b1, 1'b1);
        tx_chk(4, 1, 4'ha, 0, 1, 0);
        `CHK("tx bit four", 1'b1, tcode[4][4])
        $display("transmit test done");
    endtask

    task automatic t_rx();
        do_reset(1'b1, 1'b0);
        feed(5, 1, 0, 1, 5'h09, 4);
        `CHK("rx valid", 1'b1, mii_bus.rx_dv[5])
        `CHK("rx nibble", 4'h9, mii_bus.rxd[5])
        `CHK("mac data", 5'h09, rdat[5])
        `CHK("carrier", 1'b1, car[5])
        `CHK("mac valid", 1'b1, rvld[5])
        @(negedge mii_bus.rx_clk[5]);
        @(negedge CLK_I);
        `CHK("rx strobe", 1'b1, rstb[5])
        feed(5, 1, 1, 1, 5'h09, 4);
        `CHK("rx error bad", 1'b1, rerr[5])
        feed(5, 1, 0, 0, 5'h09, 4);
        `CHK("rx error lock", 1'b1, mii_bus.rx_er[5])
        feed(5, 0, 0, 1, 5'h00, 4);
        `CHK("rx idle", 2'b00, {mii_bus.rx_dv[5], mii_bus.crs[5]})
        do_reset(1'b1, 1'b1);
        feed(5, 1, 0, 1, 5'h1a, 4);
        `CHK("rx bit four", 1'b1, mii_bus.rx_er[5])
        `CHK("mac symbol", 6'h1a, {rerr[5], rdat[5]})
        $display("receive test done");
    endtask

    task automatic t_sfd(input hxm_nib_type fst, input hxm_nib_type snd,
                         input logic er);
        hxm_nib_type q[10];
        int k;
        int seen;
        k = -1;
        q = '{4'h5, 4'h5, 4'h5, fst, snd, 4'h3, 4'hc, 4'h0, 4'h0, 4'h0};
        do_reset(1'b0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            feed(2, i < 7, 0, 1, {1'b0, q[i]}, 1);
            if (k < 0 && mii_bus.rx_dv[2] === 1'b1) begin
                k = i;
                `CHK("sfd first", fst, mii_bus.rxd[2])
                `CHK("sfd error", er, mii_bus.rx_er[2])
            end else if (k >= 0 && i == k + 1) begin
                `CHK("sfd second", snd, mii_bus.rxd[2])
            end
        end
        `CHK("sfd seen", 1'b1, k >= 0)
        // Frame end crosses into the system clock a few cycles late
        seen = 0;
        repeat (8) begin
            @(negedge CLK_I);
            seen += int'(fdone[2] === 1'b1);
        end
        `CHK("frame done", 1, seen)
        `CHK("frame bad", er, fbad[2])
        $display("frame start test done");
    endtask

    task automatic t_col();
        do_reset(1'b1, 1'b0);
        act[1] = 1'b1;
        @(negedge CLK_I);
        `CHK("carrier rise", 1'b1, mii_bus.crs[1])
        tvld[1] = 1'b1;
        repeat (3) @(posedge stb[1]);
        repeat (2) @(negedge CLK_I);
        `CHK("collision", 6'h02, mii_bus.col)
        repeat (3) @(negedge CLK_I);
        `CHK("mac collision", 1'b1, coll[1])
        fdx[1] = 1'b1;
        repeat (2) @(negedge CLK_I);
        `CHK("full duplex col", 1'b0, mii_bus.col[1])
        act[1] = 1'b0;
        repeat (12) @(negedge CLK_I);
        `CHK("full duplex crs", 1'b0, mii_bus.crs[1])
        fdx[1] = 1'b0;
        repeat (2) @(negedge CLK_I);
        `CHK("half duplex crs", 1'b1, mii_bus.crs[1])
        tvld[1] = 1'b0;
        repeat (40) @(negedge CLK_I);
        `CHK("carrier loss", 1'b0, mii_bus.crs[1])
        $display("carrier test done");
    endtask

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        failures++;
        $display("BAD watchdog exp done got hang");
        stop_test();
    end

    initial begin
        t_tx();
        t_rx();
        t_sfd(4'h5, 4'hd, 1'b0);
        t_sfd(4'ha, 4'h2, 1'b1);
        t_col();
        stop_test();
    end
endmodule

`default_nettype wire
